// [snc_pkg.sv]
// package: register map, field layout and types of the signal notification channels
package snc_pkg;
  // apb register byte offsets
  localparam logic [7:0] SIG0_OFF   = 8'h00;
  localparam logic [7:0] SIG1_OFF   = 8'h04;
  localparam logic [7:0] MODE_OFF   = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  // mode register fields: 1 selects accumulate
  localparam int MODE_SIG0_BIT = 0;
  localparam int MODE_SIG1_BIT = 1;
  // status register fields: pending flags
  localparam int STAT_SIG0_BIT = 0;
  localparam int STAT_SIG1_BIT = 1;
  // reset values
  localparam logic [31:0] SIG_RST  = 32'h0000_0000;
  localparam logic [1:0]  MODE_RST = 2'h0;
  // channel numbers seen by the core's read port
  localparam logic [6:0] CH_SIG0 = 7'h03;
  localparam logic [6:0] CH_SIG1 = 7'h04;
  // width of a scalar channel word
  localparam int WORD_W = 32;
  // sender write carried to a slot
  typedef struct packed {
    logic        wr;
    logic        acc;
    logic [31:0] data;
  } snc_post_s;
  // channel request from the core
  typedef struct packed {
    logic       rd;
    logic       cnt;
    logic [6:0] ch;
  } snc_chreq_s;
endpackage : snc_pkg

// [snc_slot.sv]
// one notification register with replace/accumulate writes and clearing read
module snc_slot (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire snc_pkg::snc_post_s post_i,
  input  wire logic              clr_i,
  output logic [31:0]            value_o,
  output logic                   pend_o
);
  logic [31:0] val_reg;
  logic [31:0] val_next;
  logic        pend_reg;
  logic        pend_next;

  always_comb begin
    val_next  = val_reg;
    pend_next = pend_reg;
    // clear first so a write in the same cycle survives
    if (clr_i) begin
      val_next  = snc_pkg::SIG_RST;
      pend_next = 1'b0;
    end
    if (post_i.wr) begin
      if (post_i.acc) begin
        val_next = (clr_i ? snc_pkg::SIG_RST : val_reg) | post_i.data;
      end else begin
        val_next = post_i.data;
      end
      pend_next = (val_next != snc_pkg::SIG_RST);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_reg  <= snc_pkg::SIG_RST;
      pend_reg <= 1'b0;
    end else begin
      val_reg  <= val_next;
      pend_reg <= pend_next;
    end
  end

  assign value_o = val_reg;
  assign pend_o  = pend_reg;
endmodule : snc_slot

// [snc_top.sv]
// Our own choices: the address map and the APB interface to the registers.
module snc_top (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [3:0]         pstrb_i,
  output logic                    pready_o,
  output logic [31:0]             prdata_o,
  output logic                    pslverr_o,
  // local core channel port, read-only
  input  wire snc_pkg::snc_chreq_s ch_req_i,
  output logic                    ch_ack_o,
  output logic [31:0]             ch_data_o,
  output logic [1:0]              pending_o
);
  typedef enum logic [1:0] {SNC_IDLE, SNC_WAIT, SNC_DONE} snc_ch_e;

  function automatic logic [31:0] pend_count(input logic p);
    pend_count = {31'h0000_0000, p};
  endfunction : pend_count

  // apb decode; one wait-free access phase
  logic        acc_en;
  logic        wr_en;
  logic        hit;
  assign acc_en = psel_i & penable_i;
  assign wr_en  = acc_en & pwrite_i & (pstrb_i == 4'hf);
  assign hit    = (paddr_i == snc_pkg::SIG0_OFF) | (paddr_i == snc_pkg::SIG1_OFF) |
                  (paddr_i == snc_pkg::MODE_OFF) | (paddr_i == snc_pkg::STATUS_OFF);

  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  logic [31:0] val0;
  logic [31:0] val1;
  logic        pnd0;
  logic        pnd1;
  logic        clr0;
  logic        clr1;
  snc_pkg::snc_post_s post0;
  snc_pkg::snc_post_s post1;

  always_comb begin
    post0.wr   = wr_en & (paddr_i == snc_pkg::SIG0_OFF);
    post0.acc  = mode_reg[snc_pkg::MODE_SIG0_BIT];
    post0.data = pwdata_i;
    post1.wr   = wr_en & (paddr_i == snc_pkg::SIG1_OFF);
    post1.acc  = mode_reg[snc_pkg::MODE_SIG1_BIT];
    post1.data = pwdata_i;
  end

  // replace and accumulate handling live in the slot
  snc_slot u_slot0 (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .post_i  (post0),
    .clr_i   (clr0),
    .value_o (val0),
    .pend_o  (pnd0)
  );
  snc_slot u_slot1 (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .post_i  (post1),
    .clr_i   (clr1),
    .value_o (val1),
    .pend_o  (pnd1)
  );

  always_comb begin
    mode_next    = mode_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = psel_i & ~penable_i;
    pslverr_next = psel_i & ~penable_i & ~hit;
    if (wr_en && paddr_i == snc_pkg::MODE_OFF) begin
      mode_next = pwdata_i[1:0];
    end
    if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        snc_pkg::SIG0_OFF:   prdata_next = val0;
        snc_pkg::SIG1_OFF:   prdata_next = val1;
        snc_pkg::MODE_OFF:   prdata_next = {30'h0000_0000, mode_reg};
        snc_pkg::STATUS_OFF: prdata_next = {30'h0000_0000, pnd1, pnd0};
        default:             prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // channel side
  snc_ch_e     st_reg;
  snc_ch_e     st_next;
  logic [6:0]  ch_reg;
  logic [6:0]  ch_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] cdata_reg;
  logic [31:0] cdata_next;
  logic        bus_sig_wr;
  logic        want0;
  logic        want1;
  logic [6:0]  cur_ch;

  // any bus write to a notification register defers the clearing read
  assign bus_sig_wr = post0.wr | post1.wr;
  assign cur_ch = (st_reg == SNC_WAIT) ? ch_reg : ch_req_i.ch;
  assign want0 = (cur_ch == snc_pkg::CH_SIG0);
  assign want1 = (cur_ch == snc_pkg::CH_SIG1);

  always_comb begin
    st_next    = st_reg;
    ch_next    = ch_reg;
    ack_next   = 1'b0;
    cdata_next = cdata_reg;
    clr0       = 1'b0;
    clr1       = 1'b0;
    case (st_reg)
      SNC_IDLE: begin
        if (ch_req_i.cnt) begin
          ack_next = 1'b1;
          // count shows pending only, reserved channels give zero
          cdata_next = want0 ? pend_count(pnd0) :
                       want1 ? pend_count(pnd1) : 32'h0000_0000;
          st_next = SNC_DONE;
        end else if (ch_req_i.rd) begin
          ch_next = ch_req_i.ch;
          if (!want0 && !want1) begin
            ack_next   = 1'b1;
            cdata_next = 32'h0000_0000;
            st_next    = SNC_DONE;
          end else begin
            st_next = SNC_WAIT;
          end
        end
      end
      SNC_WAIT: begin
        // stall until pending; bus write to a slot has priority
        if (!bus_sig_wr && ((want0 && pnd0) || (want1 && pnd1))) begin
          ack_next   = 1'b1;
          cdata_next = want0 ? val0 : val1;
          clr0       = want0;
          clr1       = want1;
          st_next    = SNC_DONE;
        end
      end
      SNC_DONE: begin
        st_next = SNC_IDLE;
      end
      default: begin
        st_next = SNC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg    <= snc_pkg::MODE_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      st_reg      <= SNC_IDLE;
      ch_reg      <= 7'h00;
      ack_reg     <= 1'b0;
      cdata_reg   <= 32'h0000_0000;
    end else begin
      mode_reg    <= mode_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      st_reg      <= st_next;
      ch_reg      <= ch_next;
      ack_reg     <= ack_next;
      cdata_reg   <= cdata_next;
    end
  end

  // pending flags registered for the outside; no interrupt is raised
  logic [1:0] pend_reg;
  logic [1:0] pend_next;
  always_comb begin
    pend_next = {pnd1, pnd0};
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 2'h0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign pready_o  = pready_reg;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg;
  assign ch_ack_o  = ack_reg;
  assign ch_data_o = cdata_reg;
  assign pending_o = pend_reg;

  // checks
  a_clear_after_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT && clr0 && !post0.wr)
    |=> (val0 == 32'h0000_0000 && !pnd0))
    else $error("channel read did not clear register 0");

  a_clear_read_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT && clr1 && !post1.wr)
    |=> (val1 == 32'h0000_0000 && !pnd1))
    else $error("channel read did not clear register 1");

  a_bus_read_keeps: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (acc_en && !pwrite_i && !clr0 && !post0.wr)
    |=> ($stable(val0) && $stable(pnd0)))
    else $error("bus read altered register 0");

  a_bus_read_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (acc_en && !pwrite_i && !clr1 && !post1.wr)
    |=> ($stable(val1) && $stable(pnd1)))
    else $error("bus read altered register 1");

  a_stall_no_pend: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT && !pnd0 && !pnd1)
    |=> !ack_reg)
    else $error("channel read completed with nothing pending");

  a_ack_one_cycle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ack_reg
    |=> !ack_reg)
    else $error("channel answer stood longer than one cycle");

  a_replace_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (post0.wr && !post0.acc)
    |=> (val0 == $past(pwdata_i)))
    else $error("replace write did not overwrite register 0");

  a_replace_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (post1.wr && !post1.acc)
    |=> (val1 == $past(pwdata_i)))
    else $error("replace write did not overwrite register 1");

  a_or_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (post1.wr && post1.acc && !clr1)
    |=> (val1 == ($past(val1) | $past(pwdata_i))))
    else $error("accumulate write did not or in");

  a_or_write_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (post0.wr && post0.acc && !clr0)
    |=> (val0 == ($past(val0) | $past(pwdata_i))))
    else $error("accumulate write did not or into register 0");

  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_IDLE && (ch_req_i.rd || ch_req_i.cnt) && !want0 && !want1)
    |=> (ack_reg && ch_data_o == 32'h0000_0000))
    else $error("reserved channel returned nonzero");

  a_bus_priority: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    bus_sig_wr
    |-> !(clr0 || clr1))
    else $error("channel clear collided with bus write");

  a_count_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_IDLE && ch_req_i.cnt && want1)
    |=> (ch_data_o == {31'h0, $past(pnd1)}))
    else $error("count does not match pending");

  a_count_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_IDLE && ch_req_i.cnt && want0)
    |=> (ch_data_o == {31'h0, $past(pnd0)}))
    else $error("count of register 0 does not match pending");

  a_read_data_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT && clr0)
    |=> (ch_ack_o && ch_data_o == $past(val0)))
    else $error("channel read of register 0 returned wrong word");

  a_read_data_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT && clr1)
    |=> (ch_ack_o && ch_data_o == $past(val1)))
    else $error("channel read of register 1 returned wrong word");

  a_pend_track_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pnd0 == (val0 != 32'h0000_0000))
    else $error("pending flag of register 0 disagrees with contents");

  a_pend_track_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pnd1 == (val1 != 32'h0000_0000))
    else $error("pending flag of register 1 disagrees with contents");

  a_pend_out_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    1'b1
    |=> (pending_o[0] == $past(pnd0) && pending_o[1] == $past(pnd1)))
    else $error("pending output does not follow the registers");

  a_bus_ready: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i)
    |=> pready_o)
    else $error("bus access phase without ready");

  a_bus_rdata_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == snc_pkg::SIG0_OFF)
    |=> (prdata_o == $past(val0)))
    else $error("bus read of register 0 returned wrong word");

  a_bus_rdata_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == snc_pkg::SIG1_OFF)
    |=> (prdata_o == $past(val1)))
    else $error("bus read of register 1 returned wrong word");

  a_unmapped_error: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !hit)
    |=> pslverr_o)
    else $error("unmapped bus access gave no error");

  a_no_chan_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!post0.wr && !clr0 && !post1.wr && !clr1)
    |=> ($stable(val0) && $stable(val1)))
    else $error("register changed without bus write or clearing read");

  a_wait_own_ch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == SNC_WAIT)
    |-> (want0 || want1))
    else $error("channel read waits on a foreign register");
endmodule : snc_top

// [snc_sender.sv]
// remote sender model: apb master that delivers signals and reads them back
module snc_sender (
  input  wire logic        mclk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [3:0]       pstrb_o,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'hff;
    pwdata_o  = 32'h0;
    pstrb_o   = 4'hf;
  end
  // plain, fenced and barriered sends all reach the slot as this one write
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel_o   <= 1'b1;
    pwrite_o <= wr;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    // no limit here: only the bench watchdog ends a wait
    do begin
      @(posedge mclk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released lines stop showing the last value
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask : xfer
endmodule : snc_sender

// [tb_snc_top.sv]
// self-checking bench for the signal notification channels
module tb_snc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk = 1'b0;
  logic                rst_n = 1'b0;
  logic                psel, penable, pwrite, pready, pslverr, ch_ack;
  logic [7:0]          paddr;
  logic [3:0]          pstrb;
  logic [31:0]         pwdata, prdata, ch_data, d;
  logic [1:0]          pending;
  snc_pkg::snc_chreq_s ch_req = '0;
  int                  error_cnt = 0;
  int                  n_compared = 0;
  int                  n;

  snc_top dut (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .ch_req_i(ch_req),
    .ch_ack_o(ch_ack), .ch_data_o(ch_data), .pending_o(pending));
  snc_sender u_snd (.mclk_i(mclk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .pready_i(pready),
    .prdata_i(prdata), .pslverr_i(pslverr));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    logic e;
    u_snd.xfer(wr, a, wd, r, e);
    chk("slave error", {31'h0, a > snc_pkg::STATUS_OFF}, {31'h0, e});
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk("bus read", exp, r);
  endtask : rchk

  task automatic chan(input logic rd, input logic cnt, input logic [6:0] ch,
                      output logic [31:0] r, output int k);
    k = 0;
    @(posedge mclk);
    ch_req <= {rd, cnt, ch};
    do begin
      @(posedge mclk);
      k++;
    end while (ch_ack !== 1'b1 && k < 200);
    r = ch_data;
    ch_req <= '0;
    @(posedge mclk);
    if (k >= 200) error_cnt++;
  endtask : chan

  task automatic t_reset;
    rchk(snc_pkg::SIG0_OFF, 32'h0);
    rchk(snc_pkg::SIG1_OFF, 32'h0);
    rchk(snc_pkg::MODE_OFF, 32'h0);
    rchk(snc_pkg::STATUS_OFF, 32'h0);
  endtask : t_reset

  task automatic t_replace;
    bus(1'b1, snc_pkg::SIG0_OFF, 32'h1234_5678, d);
    bus(1'b1, snc_pkg::SIG0_OFF, 32'h8000_0001, d);
    rchk(snc_pkg::SIG0_OFF, 32'h8000_0001);
    rchk(snc_pkg::SIG0_OFF, 32'h8000_0001);
    rchk(snc_pkg::STATUS_OFF, 32'h1);
    chan(1'b0, 1'b1, snc_pkg::CH_SIG0, d, n);
    chk("count", 32'h1, d);
    chan(1'b1, 1'b0, snc_pkg::CH_SIG0, d, n);
    chk("channel data", 32'h8000_0001, d);
    rchk(snc_pkg::SIG0_OFF, 32'h0);
    chan(1'b0, 1'b1, snc_pkg::CH_SIG0, d, n);
    chk("count", 32'h0, d);
    chk("pending", 32'h0, {30'h0, pending});
    bus(1'b1, snc_pkg::SIG1_OFF, 32'h0000_0055, d);
    rchk(snc_pkg::SIG1_OFF, 32'h0000_0055);
  endtask : t_replace

  task automatic t_accum;
    bus(1'b1, snc_pkg::MODE_OFF, 32'h2, d);
    rchk(snc_pkg::MODE_OFF, 32'h2);
    bus(1'b1, snc_pkg::SIG1_OFF, 32'h0000_00f0, d);
    bus(1'b1, snc_pkg::SIG1_OFF, 32'h8000_000f, d);
    bus(1'b1, snc_pkg::SIG0_OFF, 32'h3, d);
    // pending flags trail the registers by one cycle
    repeat (2) @(posedge mclk);
    chk("pending", 32'h3, {30'h0, pending});
    chan(1'b1, 1'b0, snc_pkg::CH_SIG1, d, n);
    chk("channel data", 32'h8000_00ff, d);
    rchk(snc_pkg::SIG0_OFF, 32'h3);
    chan(1'b1, 1'b0, snc_pkg::CH_SIG0, d, n);
    chk("channel data", 32'h3, d);
  endtask : t_accum

  task automatic t_block;
    logic [31:0] r;
    fork
      chan(1'b1, 1'b0, snc_pkg::CH_SIG0, d, n);
      begin
        repeat (8) @(posedge mclk);
        bus(1'b1, snc_pkg::SIG0_OFF, 32'h0000_0a5a, r);
      end
    join
    chk("channel data", 32'h0000_0a5a, d);
    chk("stalled", 32'h1, {31'h0, n > 9});
    // the bus write lands in the cycle the clearing read would take
    bus(1'b1, snc_pkg::SIG1_OFF, 32'h0000_0100, r);
    fork
      chan(1'b1, 1'b0, snc_pkg::CH_SIG1, d, n);
      bus(1'b1, snc_pkg::SIG1_OFF, 32'h0000_0002, r);
    join
    chk("channel data", 32'h0000_0102, d);
    rchk(snc_pkg::SIG1_OFF, 32'h0);
  endtask : t_block

  task automatic t_reserved;
    bus(1'b1, 8'h10, 32'hffff_ffff, d);
    bus(1'b1, snc_pkg::SIG1_OFF, 32'h77, d);
    chan(1'b1, 1'b0, 7'h05, d, n);
    chk("reserved data", 32'h0, d);
    chan(1'b0, 1'b1, 7'h00, d, n);
    chk("reserved count", 32'h0, d);
    rchk(snc_pkg::SIG1_OFF, 32'h77);
    chan(1'b0, 1'b1, snc_pkg::CH_SIG1, d, n);
    chk("count", 32'h1, d);
    bus(1'b1, snc_pkg::MODE_OFF, 32'h3, d);
    bus(1'b1, snc_pkg::SIG0_OFF, 32'h10, d);
    bus(1'b1, snc_pkg::SIG0_OFF, 32'h01, d);
    rchk(snc_pkg::SIG0_OFF, 32'h11);
  endtask : t_reserved

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_replace();
    t_accum();
    t_block();
    t_reserved();
    finish_test();
  end
endmodule : tb_snc_top
